// file: hw/gcm_command_map.sv
// host command map of the gauge: codes, control word, storage, scratch
`timescale 1ns/100ps
module gcm_command_map
#(
  parameter logic [6:0] DEV_ADDR = 7'h55,
  parameter logic [15:0] DEVICE_TYPE = 16'h1234, // arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0100, // arbitrary value
  parameter logic [15:0] UNLOCK_KEY = 16'h5a5a, // arbitrary value
  parameter logic [7:0] USER_SUBCLASS = 8'h3a,
  parameter logic [15:0] BUILD_DAY = 16'h0000,
  parameter logic [15:0] PACK_SERIAL_CODE = 16'h0001,
  parameter logic [7:0] MAKER_LABEL_LEN = 8'h0b,
  parameter logic [87:0] MAKER_LABEL = "GAUGEMAKER ",
  parameter logic [7:0] CELL_TYPE_LEN = 8'h04,
  parameter logic [31:0] CELL_TYPE = "LION"
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire gcm_pkg::gcm_values_t values,
  input wire logic sleep_cond,
  output gcm_pkg::gcm_pmode_t power_mode,
  output logic open_access_mode,
  output logic auth_start,
  input wire logic auth_done,
  input wire logic [159:0] auth_resp
);
  import gcm_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  gcm_bus_evt_t evt; // byte events from the port
  logic [7:0] code; // current command code pointer
  logic [7:0] ctl_lo; // low byte of pending sub-command
  logic [15:0] ctl_word; // command port read value
  logic ctl_is_status; // command port shows live status
  logic locked_access_mode; // locked after reset
  logic [7:0] store_subclass; // storage subclass select
  logic [7:0] store_offset; // storage offset select
  logic [7:0] store_mem [STORE_BYTES]; // user storage
  logic [7:0] scratch [SCRATCH_BYTES]; // challenge and response area
  logic [7:0] auth_key [KEY_BYTES]; // authentication key
  logic arm_fullsleep; // one-cycle request for full sleep
  logic fullsleep_armed; // full sleep pending
  logic [7:0] rd_byte; // byte offered to the port
  logic [15:0] status_word; // control status value

  assign open_access_mode = ~locked_access_mode;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // byte of a two-byte value: even code low, odd code high
  function automatic logic [7:0] word_byte(input logic [15:0] w,
                                           input logic hi);
    word_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // byte index of a code inside a block that starts at base
  function automatic logic [7:0] rel(input logic [7:0] c,
                                     input logic [7:0] base);
    rel = c - base;
  endfunction

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire [7:0] pair = {code[7:1], 1'b0};
  wire hi_half = code[0];
  wire in_name = code >= CODE_MAKER_LABEL_BLOCK
               && code <= CODE_MAKER_LABEL_LAST;
  wire in_cell_type_text = code >= CODE_CELL_TYPE_TEXT && code <= CODE_CELL_TYPE_LAST;
  wire in_scratch = code >= CODE_SCRATCH_FIRST && code <= CODE_SCRATCH_LAST;
  wire in_key = code >= CODE_KEY_FIRST && code <= CODE_KEY_LAST;
  wire [7:0] name_idx = rel(code, CODE_MAKER_LABEL_BLOCK);
  wire [7:0] cell_type_text_idx = rel(code, CODE_CELL_TYPE_TEXT);
  wire [4:0] scr_idx = 5'(rel(code, CODE_SCRATCH_FIRST));
  wire [3:0] key_idx = 4'(rel(code, CODE_KEY_FIRST));
  wire store_hit = store_subclass == USER_SUBCLASS
                 && store_offset < 8'(STORE_BYTES);
  wire [4:0] store_idx = store_offset[4:0];
  wire wr_data = evt.wr_stb & ~evt.wr_first;
  wire [15:0] sub_cmd = {evt.wr_byte, ctl_lo};
  wire sub_done = wr_data && code == 8'h01; // high byte closes it

  // live status word
  always_comb
  begin
    status_word = 16'h0000;
    status_word[STAT_LOCKED_BIT] = locked_access_mode;
    status_word[STAT_FULLSLEEP_BIT] = fullsleep_armed;
    status_word[STAT_SLEEP_BIT] = power_mode == PM_SLEEP;
  end

  // -----------------------------------------------------------------
  // read selection
  // -----------------------------------------------------------------
  function automatic logic [7:0] read_map(input logic [7:0] c);
    logic [15:0] w;
    w = 16'h0000;
    unique case (c[7:1] == 7'h00 ? CODE_COMMAND_PORT : pair)
      CODE_COMMAND_PORT: w = ctl_is_status ? status_word : ctl_word;
      CODE_CHARGE_PERCENT: w = values.charge_percent;
      CODE_REMAINING_CHARGE: w = values.remaining_charge;
      CODE_FULL_CAPACITY: w = values.full_capacity;
      CODE_PACK_POTENTIAL: w = values.pack_potential;
      CODE_MEAN_CURRENT: w = values.mean_current;
      CODE_THERMAL_READING: w = values.thermal_reading;
      CODE_GAUGE_STATUS_BITS: w = values.gauge_status_bits;
      CODE_PACK_SERIAL_CODE: w = PACK_SERIAL_CODE;
      default: w = 16'h0000;
    endcase
    read_map = word_byte(w, c[0]);
  endfunction

  // build day sits on an odd pair, so it is handled apart
  wire [7:0] day_byte = word_byte(BUILD_DAY, code == CODE_BUILD_DAY + 8'h1);
  wire is_day = code == CODE_BUILD_DAY || code == CODE_BUILD_DAY + 8'h1;

  assign rd_byte =
      is_day ? day_byte :
      code == CODE_MAKER_LABEL_LEN ? MAKER_LABEL_LEN :
      in_name ? MAKER_LABEL[8'd87 - {name_idx[4:0], 3'b000} -: 8] :
      code == CODE_CELL_TYPE_LEN ? CELL_TYPE_LEN :
      in_cell_type_text ? CELL_TYPE[8'd31 - {cell_type_text_idx[4:0], 3'b000} -: 8] :
      code == CODE_STORE_SUBCLASS ? store_subclass :
      code == CODE_STORE_OFFSET ? store_offset :
      code == CODE_STORE_DATA ? (store_hit ? store_mem[store_idx] : 8'h00) :
      in_scratch ? scratch[scr_idx] :
      in_key ? 8'h00 : // keys never read back
      read_map(code);

  // -----------------------------------------------------------------
  // serial port and power tracker
  // -----------------------------------------------------------------
  gcm_serial_port #(.DEV_ADDR(DEV_ADDR)) u_port
  (
    .mclk(mclk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .rd_byte(rd_byte),
    .evt(evt)
  );

  gcm_power_mode u_power
  (
    .mclk(mclk),
    .reset(reset),
    .sleep_cond(sleep_cond),
    .activity(evt.activity),
    .arm_fullsleep(arm_fullsleep),
    .mode(power_mode),
    .fullsleep_armed(fullsleep_armed)
  );

  // -----------------------------------------------------------------
  // code pointer: set by the first written byte, then auto-increment
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
      code <= CODE_COMMAND_PORT;
    else if (evt.wr_stb & evt.wr_first)
      code <= evt.wr_byte;
    else if (wr_data | evt.rd_stb)
      code <= code + 8'h01;
  end

  // -----------------------------------------------------------------
  // command port: only writable standard code pair
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    arm_fullsleep <= 1'b0;
    if (reset)
    begin
      ctl_lo <= 8'h00;
      ctl_word <= 16'h0000;
      ctl_is_status <= 1'b1;
      locked_access_mode <= 1'b1;
    end
    else if (wr_data && code == CODE_COMMAND_PORT)
      ctl_lo <= evt.wr_byte;
    else if (sub_done)
    begin
      ctl_is_status <= 1'b0;
      ctl_word <= 16'h0000;
      if (sub_cmd == SUB_STATUS)
        ctl_is_status <= 1'b1;
      else if (sub_cmd == SUB_DEVICE_TYPE)
        ctl_word <= DEVICE_TYPE;
      else if (sub_cmd == SUB_FW_VERSION)
        ctl_word <= FW_VERSION;
      else if (sub_cmd == SUB_SET_FULLSLEEP && ~locked_access_mode)
        arm_fullsleep <= 1'b1;
      else if (sub_cmd == SUB_LOCK)
        locked_access_mode <= 1'b1;
      else if (sub_cmd == UNLOCK_KEY)
        locked_access_mode <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // storage select and user storage; values outside read-only
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      store_subclass <= STORE_SUBCLASS_RESET;
      store_offset <= STORE_OFFSET_RESET;
    end
    else if (wr_data && code == CODE_STORE_SUBCLASS)
      store_subclass <= evt.wr_byte;
    else if (wr_data && code == CODE_STORE_OFFSET)
      store_offset <= evt.wr_byte;
  end

  // storage contents are not reset: they model retained memory
  always_ff @(posedge mclk)
  begin
    if (wr_data && code == CODE_STORE_DATA && store_hit)
      store_mem[store_idx] <= evt.wr_byte;
  end

  // -----------------------------------------------------------------
  // authentication: keys, scratch pad, start pulse
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (wr_data && in_key && ~locked_access_mode)
      auth_key[key_idx] <= evt.wr_byte;
  end

  // response wins over a host write in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < SCRATCH_BYTES; gi++)
    begin : g_scratch
      always_ff @(posedge mclk)
      begin
        if (reset)
          scratch[gi] <= 8'h00;
        else if (auth_done)
          scratch[gi] <= auth_resp[159 - 8 * gi -: 8];
        else if (wr_data && in_scratch && scr_idx == 5'(gi))
          scratch[gi] <= evt.wr_byte;
      end
    end
  endgenerate

  // one-cycle request for the hash engine
  always_ff @(posedge mclk)
  begin
    auth_start <= ~reset & wr_data & (code == CODE_AUTH_GO);
  end
endmodule

// file: hw/gcm_pkg.sv
// constants, types and field layouts for the gauge command map
package gcm_pkg;
  // -----------------------------------------------------------------
  // command codes
  // -----------------------------------------------------------------
  localparam logic [7:0] CODE_COMMAND_PORT = 8'h00;
  localparam logic [7:0] CODE_CHARGE_PERCENT = 8'h02;
  localparam logic [7:0] CODE_REMAINING_CHARGE = 8'h04;
  localparam logic [7:0] CODE_FULL_CAPACITY = 8'h06;
  localparam logic [7:0] CODE_PACK_POTENTIAL = 8'h08;
  localparam logic [7:0] CODE_MEAN_CURRENT = 8'h0a;
  localparam logic [7:0] CODE_THERMAL_READING = 8'h0c;
  localparam logic [7:0] CODE_GAUGE_STATUS_BITS = 8'h0e;
  localparam logic [7:0] CODE_BUILD_DAY = 8'h6b;
  localparam logic [7:0] CODE_MAKER_LABEL_LEN = 8'h6d;
  localparam logic [7:0] CODE_MAKER_LABEL_BLOCK = 8'h6e;
  localparam logic [7:0] CODE_MAKER_LABEL_LAST = 8'h78;
  localparam logic [7:0] CODE_CELL_TYPE_LEN = 8'h79;
  localparam logic [7:0] CODE_CELL_TYPE_TEXT = 8'h7a;
  localparam logic [7:0] CODE_CELL_TYPE_LAST = 8'h7d;
  localparam logic [7:0] CODE_PACK_SERIAL_CODE = 8'h7e;
  // storage, scratch pad and key window
  localparam logic [7:0] CODE_STORE_SUBCLASS = 8'h3e;
  localparam logic [7:0] CODE_STORE_OFFSET = 8'h3f;
  localparam logic [7:0] CODE_SCRATCH_FIRST = 8'h40;
  localparam logic [7:0] CODE_SCRATCH_LAST = 8'h53;
  localparam logic [7:0] CODE_AUTH_GO = 8'h54;
  localparam logic [7:0] CODE_STORE_DATA = 8'h60;
  localparam logic [7:0] CODE_KEY_FIRST = 8'h64;
  localparam logic [7:0] CODE_KEY_LAST = 8'h73;
  // -----------------------------------------------------------------
  // sizes and sub-commands
  // -----------------------------------------------------------------
  localparam int STORE_BYTES = 32;
  localparam int SCRATCH_BYTES = 20;
  localparam int KEY_BYTES = 16;
  localparam logic [15:0] SUB_STATUS = 16'h0000;
  localparam logic [15:0] SUB_DEVICE_TYPE = 16'h0001;
  localparam logic [15:0] SUB_FW_VERSION = 16'h0002;
  localparam logic [15:0] SUB_SET_FULLSLEEP = 16'h0010;
  localparam logic [15:0] SUB_LOCK = 16'h0020;
  // status word bit positions and storage select reset values
  localparam int STAT_LOCKED_BIT = 13;
  localparam int STAT_FULLSLEEP_BIT = 5;
  localparam int STAT_SLEEP_BIT = 4;
  localparam logic [7:0] STORE_SUBCLASS_RESET = 8'h00;
  localparam logic [7:0] STORE_OFFSET_RESET = 8'h00;

  // measured and computed values handed in by the gauge core
  typedef struct packed {
    logic [15:0] charge_percent;
    logic [15:0] remaining_charge;
    logic [15:0] full_capacity;
    logic [15:0] pack_potential;
    logic [15:0] mean_current;
    logic [15:0] thermal_reading;
    logic [15:0] gauge_status_bits;
  } gcm_values_t;

  // byte events from the serial port
  typedef struct packed {
    logic wr_stb;
    logic wr_first;
    logic [7:0] wr_byte;
    logic rd_stb;
    logic activity;
  } gcm_bus_evt_t;

  // power modes
  typedef enum logic [2:0] {
    PM_NORMAL = 3'b001,
    PM_SLEEP = 3'b010,
    PM_FULLSLEEP = 3'b100
  } gcm_pmode_t;

  // serial port states
  typedef enum logic [4:0] {
    SP_IDLE = 5'b00001,
    SP_RX = 5'b00010,
    SP_ACK = 5'b00100,
    SP_TX = 5'b01000,
    SP_TXACK = 5'b10000
  } gcm_sp_state_t;
endpackage

// file: hw/gcm_serial_port.sv
// two-wire slave port turning bus bits into byte events
`timescale 1ns/100ps
module gcm_serial_port
#(
  parameter logic [6:0] DEV_ADDR = 7'h55
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] rd_byte,
  output gcm_pkg::gcm_bus_evt_t evt
);
  import gcm_pkg::*;

  gcm_sp_state_t state; // port state
  logic scl_q; // previous clock level
  logic sda_q; // previous data level
  logic [7:0] shift; // byte shifter
  logic [3:0] cnt; // bit count
  logic is_addr; // first byte of a transfer
  logic rw; // read transfer
  logic first; // next written byte is the code
  logic acked; // master acked last sent byte

  // -----------------------------------------------------------------
  // bus conditions
  // -----------------------------------------------------------------
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
  wire byte_done = scl_fall & (cnt == 4'h8);
  wire addr_hit = shift[7:1] == DEV_ADDR;
  wire to_tx = scl_fall & ((state == SP_ACK & rw) | (state == SP_TXACK & acked));

  assign sda_out = 1'b0; // open-drain: only ever pulls low
  assign sda_oe = (state == SP_ACK) | (state == SP_TX & ~shift[7]);
  assign evt.wr_stb = byte_done & (state == SP_RX) & ~is_addr;
  assign evt.wr_first = first;
  assign evt.wr_byte = shift;
  assign evt.rd_stb = to_tx;
  assign evt.activity = start_c;

  // edge history
  always_ff @(posedge mclk)
  begin
    scl_q <= reset ? 1'b1 : scl_in;
    sda_q <= reset ? 1'b1 : sda_in;
  end

  // -----------------------------------------------------------------
  // byte sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset | stop_c)
    begin
      state <= SP_IDLE;
      cnt <= 4'h0;
      is_addr <= 1'b0;
      rw <= 1'b0;
      first <= 1'b0;
      acked <= 1'b0;
      shift <= 8'h00;
    end
    else if (start_c)
    begin
      state <= SP_RX;
      cnt <= 4'h0;
      is_addr <= 1'b1;
    end
    else
    begin
      unique case (state)
        SP_IDLE: ;
        SP_RX:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_in};
            cnt <= cnt + 4'h1;
          end
          else if (byte_done)
          begin
            // foreign address: stay off the bus until next start
            state <= (is_addr & ~addr_hit) ? SP_IDLE : SP_ACK;
            if (is_addr)
            begin
              rw <= shift[0];
              first <= ~shift[0];
            end
            else
              first <= 1'b0;
            is_addr <= 1'b0;
          end
        end
        SP_ACK:
        begin
          if (to_tx)
          begin
            state <= SP_TX;
            shift <= rd_byte;
            cnt <= 4'h0;
          end
          else if (scl_fall)
          begin
            state <= SP_RX;
            cnt <= 4'h0;
          end
        end
        SP_TX:
        begin
          if (scl_fall)
          begin
            shift <= {shift[6:0], 1'b1};
            cnt <= cnt + 4'h1;
            if (cnt == 4'h7)
              state <= SP_TXACK;
          end
        end
        SP_TXACK:
        begin
          if (scl_rise)
            acked <= ~sda_in;
          else if (to_tx)
          begin
            state <= SP_TX;
            shift <= rd_byte;
            cnt <= 4'h0;
          end
          else if (scl_fall)
            state <= SP_IDLE; // nack ends the read
        end
      endcase
    end
  end
endmodule

// file: hw/gcm_power_mode.sv
// automatic normal, sleep and full-sleep mode tracker
`timescale 1ns/100ps
module gcm_power_mode
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sleep_cond,
  input wire logic activity,
  input wire logic arm_fullsleep,
  output gcm_pkg::gcm_pmode_t mode,
  output logic fullsleep_armed
);
  import gcm_pkg::*;

  gcm_pmode_t next_mode; // mode for the next cycle

  // -----------------------------------------------------------------
  // mode transitions
  // -----------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      PM_NORMAL:
        if (sleep_cond & ~activity)
          next_mode = PM_SLEEP;
      PM_SLEEP:
        if (activity | ~sleep_cond)
          next_mode = PM_NORMAL;
        else if (fullsleep_armed)
          next_mode = PM_FULLSLEEP;
      PM_FULLSLEEP:
        if (activity)
          next_mode = PM_SLEEP; // traffic brings it back to sleep
      default:
        next_mode = PM_NORMAL; // illegal code recovers
    endcase
  end

  // mode register and full-sleep arm flag; arming wins over traffic
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode <= PM_NORMAL;
      fullsleep_armed <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      fullsleep_armed <= arm_fullsleep | (fullsleep_armed & ~activity);
    end
  end
endmodule

// file: verification/gcm_command_map_properties.sv
// port assertions for the gauge command map
`timescale 1ns/100ps
module gcm_command_map_properties
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire gcm_pkg::gcm_values_t values,
  input wire logic sleep_cond,
  input wire gcm_pkg::gcm_pmode_t power_mode,
  input wire logic open_access_mode,
  input wire logic auth_start,
  input wire logic auth_done,
  input wire logic [159:0] auth_resp
);
  import gcm_pkg::*;
  // ---------------------------------------------------------------
  // one clock domain, reset quiets every check
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_PIN_LOW: assert property (sda_out == 1'b0)
    else $error("data pin pull value not low");
  AST_RESET_VALUES: assert property ($past(reset) |->
    power_mode == PM_NORMAL && !open_access_mode && !auth_start && !sda_oe)
    else $error("outputs not at reset values");
  AST_MODE_ONEHOT: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  AST_AUTH_PULSE: assert property (auth_start |=> !auth_start)
    else $error("auth request longer than one cycle");
  AST_ACK_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled low while bus clock high");
  AST_SLEEP_ENTRY: assert property (($past(power_mode) == PM_NORMAL &&
    power_mode == PM_SLEEP) |-> $past(sleep_cond))
    else $error("sleep entered without sleep condition");
  AST_SLEEP_EXIT: assert property ((power_mode == PM_SLEEP &&
    !sleep_cond) |=> power_mode != PM_SLEEP)
    else $error("sleep kept without sleep condition");
  AST_NORMAL_HOLD: assert property ((power_mode == PM_NORMAL &&
    !sleep_cond) |=> power_mode == PM_NORMAL)
    else $error("normal mode left without cause");
  AST_FULL_PATH: assert property ((power_mode == PM_FULLSLEEP &&
    $past(power_mode) != PM_FULLSLEEP) |-> $past(power_mode) == PM_SLEEP)
    else $error("full sleep entered from other than sleep");
endmodule

// file: verification/gcm_host_model.sv
// two-wire bus master model standing in for the host processor
`timescale 1ns/100ps
module gcm_host_model
(
  input wire logic mclk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  // ---------------------------------------------------------------
  // wire and bit timing, all changes at falling mclk edges
  // ---------------------------------------------------------------
  logic sda_drv = 1'b1; // low = host pulls the data line
  initial scl = 1'b1;
  // pulled-up wire: low when either party pulls it
  assign sda = sda_drv & ~sda_oe;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // stop, then leave the bus free for 66 us
  task automatic stop();
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(1320);
  endtask
  // one bit: set data, raise clock, sample, lower clock
  task automatic bit_cycle(input logic b, output logic r);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // byte msb first plus the ninth acknowledge bit
  task automatic xfer(input logic [7:0] w, input logic ack_in,
    output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_cycle(w[i], r[i]);
    bit_cycle(ack_in, ack);
  endtask
endmodule

// file: verification/gcm_command_map_tb.sv
// self-checking bench for the gauge command map
`timescale 1ns/100ps
module gcm_command_map_tb;
  import gcm_pkg::*;
  // ---------------------------------------------------------------
  // bench signals
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR = 7'h55;
  localparam logic [15:0] DEV_T = 16'h2b7c; // arbitrary value
  localparam logic [15:0] KEY = 16'h3c96; // arbitrary value
  localparam logic [87:0] LABEL = "PACKMONITOR";
  localparam logic [31:0] CELL = "LFPX";
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  gcm_values_t values = '0;
  logic sleep_cond = 1'b0;
  gcm_pmode_t power_mode;
  logic open_access_mode;
  logic auth_start;
  logic auth_done = 1'b0;
  logic [159:0] auth_resp = '0;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  logic [7:0] seen; // byte last read by the host
  event got; // a read byte has arrived
  logic saw_auth = 1'b0; // sticky auth request seen
  int n_errors = 0;
  int checks = 0;
  always #25 mclk = ~mclk;
  gcm_command_map #(.DEV_ADDR(ADDR), .DEVICE_TYPE(DEV_T), .UNLOCK_KEY(KEY),
    .MAKER_LABEL(LABEL), .CELL_TYPE(CELL)) uut (.mclk(mclk), .reset(reset),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .values(values), .sleep_cond(sleep_cond), .power_mode(power_mode),
    .open_access_mode(open_access_mode), .auth_start(auth_start),
    .auth_done(auth_done), .auth_resp(auth_resp));
  gcm_host_model host (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ---------------------------------------------------------------
  // compare, note and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic note(input logic [7:0] e);
    exp_q.push_back(e);
  endtask
  // write n bytes of d, low byte first, from code c on
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    logic a;
    logic [7:0] r;
    host.start();
    host.xfer({ADDR, 1'b0}, 1'b1, r, a);
    check(a, 0);
    host.xfer(c, 1'b1, r, a);
    for (int i = 0; i < n; i++)
      host.xfer(d[8*i +: 8], 1'b1, r, a);
    host.stop();
  endtask
  // read n bytes from code c on, nack on the last one
  task automatic rd(input logic [7:0] c, input int n);
    logic a;
    logic [7:0] r;
    host.start();
    host.xfer({ADDR, 1'b0}, 1'b1, r, a);
    host.xfer(c, 1'b1, r, a);
    host.start();
    host.xfer({ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'hff, i == n - 1, seen, a);
      -> got;
    end
    host.stop();
  endtask
  task automatic rd2(input logic [7:0] c, input logic [15:0] w);
    note(w[7:0]);
    note(w[15:8]);
    rd(c, 2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // each read byte against the oldest note
  always @(got)
    check(seen, exp_q.pop_front());
  always @(posedge mclk)
    if (auth_start === 1'b1)
      saw_auth <= 1'b1;
  // hang guard
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic a;
    logic [7:0] r;
    int s;
    s = $urandom(51);
    values = 112'({$urandom(), $urandom(), $urandom(), $urandom()});
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    check(power_mode, PM_NORMAL);
    check(open_access_mode, 0);
    $display("test reset done");
    for (int k = 0; k < 7; k++)
      rd2(8'(2 + 2 * k), values[96 - 16 * k +: 16]);
    wr(CODE_PACK_POTENTIAL, ~values[48 +: 16], 2);
    rd2(CODE_PACK_POTENTIAL, values[48 +: 16]);
    $display("test values done");
    wr(CODE_COMMAND_PORT, SUB_DEVICE_TYPE, 2);
    rd2(CODE_COMMAND_PORT, DEV_T);
    wr(CODE_COMMAND_PORT, SUB_STATUS, 2);
    rd2(CODE_COMMAND_PORT, 16'h0001 << STAT_LOCKED_BIT);
    host.start();
    host.xfer({7'h56, 1'b0}, 1'b1, r, a);
    host.stop();
    check(a, 1);
    $display("test command port done");
    wr(CODE_COMMAND_PORT, KEY, 2);
    check(open_access_mode, 1);
    wr(CODE_COMMAND_PORT, SUB_SET_FULLSLEEP, 2);
    sleep_cond = 1'b1;
    repeat (8) @(negedge mclk);
    check(power_mode, PM_FULLSLEEP);
    host.start();
    host.stop();
    check(power_mode, PM_SLEEP);
    sleep_cond = 1'b0;
    repeat (4) @(negedge mclk);
    check(power_mode, PM_NORMAL);
    wr(CODE_COMMAND_PORT, SUB_LOCK, 2);
    check(open_access_mode, 0);
    wr(CODE_COMMAND_PORT, SUB_SET_FULLSLEEP, 2);
    sleep_cond = 1'b1;
    repeat (8) @(negedge mclk);
    check(power_mode, PM_SLEEP);
    sleep_cond = 1'b0;
    repeat (4) @(negedge mclk);
    $display("test modes done");
    note(8'h0b);
    for (int i = 0; i < 11; i++)
      note(LABEL[87 - 8 * i -: 8]);
    rd(CODE_MAKER_LABEL_LEN, 12);
    note(8'h04);
    for (int i = 0; i < 4; i++)
      note(CELL[31 - 8 * i -: 8]);
    rd(CODE_CELL_TYPE_LEN, 5);
    $display("test blocks done");
    r = 8'($urandom());
    wr(CODE_STORE_SUBCLASS, {8'h1f, 8'h3a}, 2);
    wr(CODE_STORE_DATA, {8'h00, r}, 1);
    note(r);
    rd(CODE_STORE_DATA, 1);
    wr(CODE_STORE_SUBCLASS, {8'h20, 8'h3a}, 2);
    note(8'h00);
    rd(CODE_STORE_DATA, 1);
    $display("test storage done");
    wr(CODE_SCRATCH_FIRST, {8'h00, ~r}, 1);
    note(~r);
    rd(CODE_SCRATCH_FIRST, 1);
    wr(CODE_AUTH_GO, 16'h0001, 1);
    check(saw_auth, 1);
    auth_resp = {5{$urandom()}};
    auth_done = 1'b1;
    @(negedge mclk);
    auth_done = 1'b0;
    rd2(CODE_SCRATCH_FIRST, {auth_resp[151:144], auth_resp[159:152]});
    // every noted byte must have been read back
    check(16'(exp_q.size()), 16'h0000);
    $display("test scratch done");
    tally_and_finish();
  end
endmodule
bind gcm_command_map gcm_command_map_properties chk (.mclk(mclk),
  .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .values(values), .sleep_cond(sleep_cond),
  .power_mode(power_mode), .open_access_mode(open_access_mode),
  .auth_start(auth_start), .auth_done(auth_done), .auth_resp(auth_resp));
